// File: pew_pkg.sv
package pew_pkg;
  localparam int unsigned CLK_MHZ = 250;
  // pin timing, printed figures
  localparam int unsigned WP_NS = 150;
  localparam int unsigned DS_NS = 50;
  localparam int unsigned AH_NS = 100;
  localparam int unsigned OE_ACC_NS = 300;
  localparam int unsigned BLC_US = 100;
  localparam int unsigned WC_MS = 10;
  localparam int unsigned INIT_MS = 10;
  // ns times round up, the access time too; us and ms times convert exactly
  localparam int unsigned WP_CYC = (WP_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned DS_CYC = (DS_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned AH_CYC = (AH_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned RD_CYC = (OE_ACC_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned BLC_CYC = BLC_US * CLK_MHZ;
  localparam int unsigned WC_CYC = WC_MS * 1000 * CLK_MHZ;
  localparam int unsigned INIT_CYC = INIT_MS * 1000 * CLK_MHZ;
  // software registers
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_ADDR = 4'h1;
  localparam logic [3:0] REG_WDATA = 4'h2;
  localparam logic [3:0] REG_STAT = 4'h3;
  localparam logic [3:0] REG_RDATA = 4'h4;
  localparam int unsigned CTRL_WRITE = 0;
  localparam int unsigned CTRL_READ = 1;
  localparam int unsigned CTRL_POLL = 2;
  localparam int unsigned STAT_BUSY = 0;
  localparam int unsigned STAT_READY = 1;
  localparam int unsigned STAT_WRDONE = 2;
  typedef enum logic [2:0] {
    PEW_IDLE  = 3'b000,
    PEW_SETUP = 3'b001,
    PEW_STRB  = 3'b011,
    PEW_HOLD  = 3'b010,
    PEW_RDWT  = 3'b110,
    PEW_POLL  = 3'b111,
    PEW_GAP   = 3'b101
  } pew_state_t;
endpackage

// File: pew_ctrl.sv
// Chosen here: the strobed register port and the register addresses.
`timescale 1ns/1ps
// Functional notes
// - write needs select, strobe low, output high
// - byte position from low bits, any order
// - host loads next byte within 100 us
// - protection enabled by three-write prefix
// - six-write sequence clears protection
module pew_ctrl
  import pew_pkg::*;
#(
  parameter int unsigned BLC_CYCLES  = BLC_CYC,
  parameter int unsigned WC_CYCLES   = WC_CYC,
  parameter int unsigned INIT_CYCLES = INIT_CYC
) (
  input  wire logic        SYS_CLK,
  input  wire logic        RST,
  input  wire logic [3:0]  REG_ADDR_IN,
  input  wire logic [31:0] REG_WDATA_IN,
  input  wire logic        REG_WR,
  input  wire logic        REG_RD,
  output logic      [31:0] REG_RDATA_OUT,
  output logic      [14:0] MEM_ADDR,
  output logic      [7:0]  MEM_DQ_O,
  input  wire logic [7:0]  MEM_DQ_I,
  output logic             MEM_DQ_OE,
  output logic             MEM_CE_N,
  output logic             MEM_OE_N,
  output logic             MEM_WE_N
);
  localparam int unsigned CW = 32;

  function automatic logic [CW-1:0] dec(input logic [CW-1:0] v);
    dec = (v == '0) ? '0 : v - 32'h1;
  endfunction

  pew_state_t       st_ff, nxt_st;
  logic [CW-1:0]    cnt_ff, nxt_cnt;
  logic [CW-1:0]    blc_ff, nxt_blc;
  logic [CW-1:0]    init_ff, nxt_init;
  logic [CW-1:0]    wc_ff, nxt_wc;
  logic [14:0]      addr_ff, nxt_addr;
  logic [7:0]       wdat_ff, nxt_wdat;
  logic [7:0]       rdat_ff, nxt_rdat;
  logic [7:0]       poll_ff, nxt_poll;
  logic             is_wr_ff, nxt_is_wr;
  logic             poll_mode_ff, nxt_poll_mode;
  logic             wrdone_ff, nxt_wrdone;
  logic             ce_n_ff, nxt_ce_n;
  logic             oe_n_ff, nxt_oe_n;
  logic             we_n_ff, nxt_we_n;
  logic             dq_oe_ff, nxt_dq_oe;
  logic [31:0]      rd_ff, nxt_rd;
  logic             busy;

  assign busy = (st_ff != PEW_IDLE);

  always_comb begin
    nxt_st        = st_ff;
    nxt_cnt       = dec(cnt_ff);
    nxt_addr      = addr_ff;
    nxt_wdat      = wdat_ff;
    nxt_rdat      = rdat_ff;
    nxt_poll      = poll_ff;
    nxt_is_wr     = is_wr_ff;
    nxt_poll_mode = poll_mode_ff;
    nxt_wrdone    = wrdone_ff;
    nxt_ce_n      = ce_n_ff;
    nxt_oe_n      = oe_n_ff;
    nxt_we_n      = we_n_ff;
    nxt_dq_oe     = dq_oe_ff;
    nxt_rd        = 32'h0;
    if (REG_WR && !busy) begin
      case (REG_ADDR_IN)
        REG_ADDR:  nxt_addr = REG_WDATA_IN[14:0];
        REG_WDATA: nxt_wdat = REG_WDATA_IN[7:0];
        default: ;
      endcase
    end
    if (REG_RD) begin
      case (REG_ADDR_IN)
        REG_ADDR:  nxt_rd = {17'h0, addr_ff};
        REG_WDATA: nxt_rd = {24'h0, wdat_ff};
        REG_STAT:  nxt_rd = {29'h0, wrdone_ff, (init_ff == '0), busy};
        REG_RDATA: nxt_rd = {24'h0, rdat_ff};
        default:   nxt_rd = 32'h0;
      endcase
    end
    case (st_ff)
      PEW_IDLE: begin
        nxt_ce_n  = 1'b1;
        nxt_oe_n  = 1'b1;
        nxt_we_n  = 1'b1;
        nxt_dq_oe = 1'b0;
        if (REG_WR && REG_ADDR_IN == REG_CTRL) begin
          if (REG_WDATA_IN[CTRL_WRITE] && init_ff == '0 && wc_ff == '0) begin
            // drive address, data and select first, write strobe follows next cycle
            nxt_is_wr     = 1'b1;
            nxt_wrdone    = 1'b0;
            nxt_dq_oe     = 1'b1;
            nxt_ce_n      = 1'b0;
            nxt_cnt       = CW'(DS_CYC);
            nxt_st        = PEW_SETUP;
          end else if (REG_WDATA_IN[CTRL_READ] || REG_WDATA_IN[CTRL_POLL]) begin
            // write flag kept so a later poll still knows the byte to watch
            nxt_poll_mode = REG_WDATA_IN[CTRL_POLL];
            nxt_ce_n      = 1'b0;
            nxt_oe_n      = 1'b0;
            nxt_cnt       = CW'(RD_CYC);
            nxt_st        = PEW_RDWT;
          end
        end
      end
      PEW_SETUP: begin
        // output drive held high for the whole write
        nxt_we_n = 1'b0; // address taken on this fall
        nxt_cnt  = CW'(WP_CYC);
        nxt_st   = PEW_STRB;
      end
      PEW_STRB: begin
        // pulse far beyond the noise filter width
        if (cnt_ff == '0) begin
          nxt_we_n = 1'b1; // data taken on this rise
          nxt_cnt  = CW'(AH_CYC);
          nxt_st   = PEW_HOLD;
        end
      end
      PEW_HOLD: begin
        if (cnt_ff == '0) begin
          nxt_ce_n   = 1'b1;
          nxt_dq_oe  = 1'b0;
          nxt_wrdone = 1'b1;
          nxt_st     = PEW_IDLE;
        end
      end
      PEW_RDWT: begin
        if (cnt_ff == '0) begin
          nxt_rdat = MEM_DQ_I;
          if (poll_mode_ff) begin
            nxt_poll = MEM_DQ_I;
            nxt_oe_n = 1'b1;
            nxt_cnt  = CW'(AH_CYC);
            nxt_st   = PEW_GAP;
          end else begin
            nxt_ce_n = 1'b1;
            nxt_oe_n = 1'b1; // bus released
            nxt_st   = PEW_IDLE;
          end
        end
      end
      PEW_GAP: begin
        if (cnt_ff == '0) begin
          nxt_oe_n = 1'b0;
          nxt_cnt  = CW'(RD_CYC);
          nxt_st   = PEW_POLL;
        end
      end
      PEW_POLL: begin
        if (cnt_ff == '0) begin
          nxt_rdat = MEM_DQ_I;
          nxt_oe_n = 1'b1;
          // done when bit 6 holds and bit 7 is true
          // bit 7 only means something after a write of ours
          if (MEM_DQ_I[6] == poll_ff[6] && (!is_wr_ff || MEM_DQ_I[7] == wdat_ff[7])) begin
            nxt_ce_n  = 1'b1;
            nxt_is_wr = 1'b0;
            nxt_st    = PEW_IDLE;
          end else begin
            nxt_poll = MEM_DQ_I;
            nxt_cnt  = CW'(AH_CYC);
            nxt_st   = PEW_GAP;
          end
        end
      end
      default: begin
        nxt_ce_n  = 1'b1;
        nxt_oe_n  = 1'b1;
        nxt_we_n  = 1'b1;
        nxt_dq_oe = 1'b0;
        nxt_st    = PEW_IDLE;
      end
    endcase
  end

  // load window, program and power-up timers
  always_comb begin
    nxt_blc  = dec(blc_ff);
    nxt_init = dec(init_ff);
    nxt_wc   = dec(wc_ff);
    if (st_ff == PEW_STRB && cnt_ff == '0) begin
      nxt_blc = CW'(BLC_CYCLES);
    end
    // a new strobe fall stops the window, so a page keeps loading
    if (st_ff == PEW_SETUP) begin
      nxt_blc = '0;
    end
    // load window expiry starts the program cycle
    if (blc_ff == CW'(1)) begin
      nxt_wc = CW'(WC_CYCLES);
    end
  end

  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      blc_ff  <= '0;
      init_ff <= CW'(INIT_CYCLES);
      wc_ff   <= '0;
    end else begin
      blc_ff  <= nxt_blc;
      init_ff <= nxt_init;
      wc_ff   <= nxt_wc;
    end
  end

  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      st_ff        <= PEW_IDLE;
      cnt_ff       <= '0;
      addr_ff      <= 15'h0000;
      wdat_ff      <= 8'h00;
      rdat_ff      <= 8'h00;
      poll_ff      <= 8'h00;
      is_wr_ff     <= 1'b0;
      poll_mode_ff <= 1'b0;
      wrdone_ff    <= 1'b0;
      ce_n_ff      <= 1'b1;
      oe_n_ff      <= 1'b1;
      we_n_ff      <= 1'b1;
      dq_oe_ff     <= 1'b0;
      rd_ff        <= 32'h0;
    end else begin
      st_ff        <= nxt_st;
      cnt_ff       <= nxt_cnt;
      addr_ff      <= nxt_addr;
      wdat_ff      <= nxt_wdat;
      rdat_ff      <= nxt_rdat;
      poll_ff      <= nxt_poll;
      is_wr_ff     <= nxt_is_wr;
      poll_mode_ff <= nxt_poll_mode;
      wrdone_ff    <= nxt_wrdone;
      ce_n_ff      <= nxt_ce_n;
      oe_n_ff      <= nxt_oe_n;
      we_n_ff      <= nxt_we_n;
      dq_oe_ff     <= nxt_dq_oe;
      rd_ff        <= nxt_rd;
    end
  end

  // page and byte position come straight from the address
  // prefix and unlock sequences are plain writes issued by software
  assign MEM_ADDR      = addr_ff;
  assign MEM_DQ_O      = wdat_ff;
  assign MEM_DQ_OE     = dq_oe_ff;
  assign MEM_CE_N      = ce_n_ff;
  assign MEM_OE_N      = oe_n_ff;
  assign MEM_WE_N      = we_n_ff;
  assign REG_RDATA_OUT = rd_ff;
endmodule

// File: pew_chk_sva.sv
`timescale 1ns/1ps
module pew_chk
  import pew_pkg::*;
(
  input wire logic        SYS_CLK,
  input wire logic        RST,
  input wire logic        REG_RD,
  input wire logic [31:0] REG_RDATA_OUT,
  input wire logic [14:0] MEM_ADDR,
  input wire logic [7:0]  MEM_DQ_O,
  input wire logic        MEM_DQ_OE,
  input wire logic        MEM_CE_N,
  input wire logic        MEM_OE_N,
  input wire logic        MEM_WE_N
);
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (RST);
  // strobe low for the full pulse width, then released
  sequence we_pulse_s;
    ##38 !MEM_WE_N ##1 MEM_WE_N;
  endsequence
  sequence hold_s;
    (!MEM_CE_N && MEM_DQ_OE && MEM_OE_N) [*8];
  endsequence
  wr_levels_a: assert property (!MEM_WE_N |-> !MEM_CE_N && MEM_OE_N && MEM_DQ_OE) else $error("bad write levels");
  rd_float_a: assert property (!MEM_OE_N |-> MEM_WE_N && !MEM_CE_N && !MEM_DQ_OE) else $error("bus fight on read");
  idle_pins_a: assert property (MEM_CE_N |-> MEM_WE_N && MEM_OE_N && !MEM_DQ_OE) else $error("strobe while idle");
  we_width_a: assert property ($fell(MEM_WE_N) |-> we_pulse_s) else $error("write pulse width");
  ce_lead_a: assert property ($fell(MEM_WE_N) |-> $past(!MEM_CE_N) && $past(MEM_DQ_OE)) else $error("select late");
  addr_hold_a: assert property (!MEM_WE_N |=> $stable(MEM_ADDR) && $stable(MEM_DQ_O)) else $error("address moved");
  data_hold_a: assert property ($rose(MEM_WE_N) |-> hold_s) else $error("hold too short");
  rdata_zero_a: assert property (!$past(REG_RD) |-> REG_RDATA_OUT == 32'h0) else $error("read data outside slot");
endmodule
bind pew_ctrl pew_chk i_chk (.SYS_CLK(SYS_CLK), .RST(RST), .REG_RD(REG_RD), .REG_RDATA_OUT(REG_RDATA_OUT),
  .MEM_ADDR(MEM_ADDR), .MEM_DQ_O(MEM_DQ_O), .MEM_DQ_OE(MEM_DQ_OE), .MEM_CE_N(MEM_CE_N), .MEM_OE_N(MEM_OE_N),
  .MEM_WE_N(MEM_WE_N));

// File: pew_mem.sv
`timescale 1ns/1ps
module pew_mem #(
  parameter int BLC_NS = 400,
  parameter int WC_NS  = 4000
) (
  input  wire logic [14:0] a,
  input  wire logic [7:0]  dq_in,
  input  wire logic        ce_n,
  input  wire logic        oe_n,
  input  wire logic        we_n,
  output logic      [7:0]  dq_out
);
  logic [7:0]  mem [0:32767];
  logic [7:0]  pg [0:63];
  logic [63:0] ld = 64'h0;
  logic [14:0] la = 15'h0;
  logic [7:0]  lastv = 8'h00;
  logic        busy = 1'b0;
  logic        tog = 1'b0;
  time         t_fall = 0;
  time         t_rise = 0;
  wire  [7:0]  rv = busy ? {~pg[la[5:0]][7], tog, a[5:0] ^ 6'h2A} : mem[a];
  wire         strb_n = ce_n | we_n;
  // no protection state kept: never armed, so nothing to survive
  initial foreach (mem[i]) mem[i] = 8'hFF;
  task automatic program_page();
    busy = 1'b1;
    #(WC_NS);
    for (int i = 0; i < 64; i++) if (ld[i]) mem[{la[14:6], 6'(i)}] = pg[i];
    ld = 64'h0;
    busy = 1'b0;
  endtask
  always @(negedge strb_n) begin
    t_fall = $time;
    la = a;
  end
  always @(posedge strb_n) if (oe_n && !busy && $time > 20 && $time - t_fall >= 20) begin
    pg[la[5:0]] = dq_in;
    ld[la[5:0]] = 1'b1;
    t_rise = $time;
    fork
      begin
        #(BLC_NS);
        if (strb_n && $time - t_rise >= BLC_NS) program_page();
      end
    join_none
  end
  always @(negedge oe_n) if (busy) tog = ~tog;
  // released bus shows a changed value, not the last one
  always @(posedge ce_n or posedge oe_n) lastv = ~rv;
  assign dq_out = (!ce_n && !oe_n && we_n) ? rv : lastv;
endmodule

// File: testbench.sv
`timescale 1ns/1ps
module testbench;
  import pew_pkg::*;
  logic        SYS_CLK = 1'b0;
  logic        RST = 1'b1;
  logic [3:0]  REG_ADDR_IN = 4'h0;
  logic [31:0] REG_WDATA_IN = 32'h0;
  logic        REG_WR = 1'b0;
  logic        REG_RD = 1'b0;
  logic [31:0] REG_RDATA_OUT;
  logic [14:0] MEM_ADDR;
  logic [7:0]  MEM_DQ_O;
  logic [7:0]  mem_q;
  logic        MEM_DQ_OE;
  logic        MEM_CE_N;
  logic        MEM_OE_N;
  logic        MEM_WE_N;
  wire  [7:0]  bus = MEM_DQ_OE ? MEM_DQ_O : mem_q;
  int          failures = 0;
  int          checks = 0;
  always #2 SYS_CLK = ~SYS_CLK;
  pew_ctrl #(.BLC_CYCLES(20), .WC_CYCLES(200), .INIT_CYCLES(10)) i_dut (.SYS_CLK(SYS_CLK), .RST(RST),
    .REG_ADDR_IN(REG_ADDR_IN), .REG_WDATA_IN(REG_WDATA_IN), .REG_WR(REG_WR), .REG_RD(REG_RD),
    .REG_RDATA_OUT(REG_RDATA_OUT), .MEM_ADDR(MEM_ADDR), .MEM_DQ_O(MEM_DQ_O), .MEM_DQ_I(bus),
    .MEM_DQ_OE(MEM_DQ_OE), .MEM_CE_N(MEM_CE_N), .MEM_OE_N(MEM_OE_N), .MEM_WE_N(MEM_WE_N));
  pew_mem i_mem (.a(MEM_ADDR), .dq_in(bus), .ce_n(MEM_CE_N), .oe_n(MEM_OE_N), .we_n(MEM_WE_N), .dq_out(mem_q));
  task automatic finish_test();
    $display("failures %0d checks %0d", failures, checks);
    if (failures == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge SYS_CLK);
    REG_WR <= 1'b1;
    REG_ADDR_IN <= a;
    REG_WDATA_IN <= d;
    @(posedge SYS_CLK);
    REG_WR <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] v);
    @(posedge SYS_CLK);
    REG_RD <= 1'b1;
    REG_ADDR_IN <= a;
    @(posedge SYS_CLK);
    REG_RD <= 1'b0;
    #1 v = REG_RDATA_OUT;
  endtask
  task automatic wait_idle();
    logic [31:0] v;
    repeat (2000) begin
      rd(REG_STAT, v);
      if (v[STAT_BUSY] === 1'b0) return;
    end
    chk(32'h1, 32'h0);
  endtask
  task automatic mem_read(input logic [14:0] a, input int m, output logic [31:0] v);
    wr(REG_ADDR, {17'h0, a});
    wr(REG_CTRL, 32'h1 << m);
    wait_idle();
    rd(REG_RDATA, v);
  endtask
  task automatic t_start();
    logic [31:0] v;
    chk({28'h0, MEM_CE_N, MEM_OE_N, MEM_WE_N, MEM_DQ_OE}, 32'hE);
    rd(REG_STAT, v);
    chk(v & (32'h1 << STAT_READY), 32'h0);
    repeat (12) @(posedge SYS_CLK);
    rd(REG_STAT, v);
    chk(v & (32'h1 << STAT_READY), 32'h1 << STAT_READY);
  endtask
  task automatic t_byte(input logic [14:0] a, input logic [7:0] d);
    logic [31:0] v;
    logic [31:0] w;
    wr(REG_ADDR, {17'h0, a});
    wr(REG_WDATA, {24'h0, d});
    wr(REG_CTRL, 32'h1 << CTRL_WRITE);
    wait_idle();
    rd(REG_STAT, v);
    chk(v & (32'h1 << STAT_WRDONE), 32'h1 << STAT_WRDONE);
    // wait out the controller's own program timer
    repeat (210) @(posedge SYS_CLK);
    mem_read(a, CTRL_READ, v);
    chk(v & 32'h80, {24'h0, ~d[7], 7'h0});
    mem_read(a, CTRL_READ, w);
    chk((v ^ w) & 32'h40, 32'h40);
    mem_read(a, CTRL_POLL, v);
    chk(v, {24'h0, d});
    mem_read(a ^ 15'h1, CTRL_READ, v);
    chk(v, 32'hFF);
  endtask
  initial begin
    repeat (6) @(posedge SYS_CLK);
    RST <= 1'b0;
    t_start();
    t_byte(15'h7FFF, 8'h3C);
    t_byte(15'h0040, 8'hC5);
    finish_test();
  end
  initial begin
    #100000;
    failures++;
    finish_test();
  end
endmodule
